// *** shared/otpcl_pkg.sv ***
// constants, types and checksum function for the one-time-programmable configuration loader
package otpcl_pkg;
  // ===================================================
  // register space layout
  localparam int CTRL_WORDS = 16;
  localparam int CTRL_IW = 4;
  localparam int FB_WORDS = 8;
  localparam int FB_IW = 3;
  localparam int DW = 8;
  localparam logic [CTRL_IW-1:0] LOAD_LAST = 4'hF;
  localparam logic [7:0] CTRL_LIMIT = 8'h10;
  localparam logic [7:0] FB_BASE = 8'h40;
  localparam logic [7:0] FB_LIMIT = 8'h48;
  localparam logic [7:0] RESTART_ADDR = 8'hF0;
  localparam logic [7:0] RESET_WORD = 8'h00;
  // ===================================================
  // control word indices and fields
  localparam logic [CTRL_IW-1:0] CFG_ALWAYS_ON = 4'h0;
  localparam logic [CTRL_IW-1:0] CFG_GPIO_MODE = 4'h1;
  localparam logic [CTRL_IW-1:0] CFG_GPIO_DIR = 4'h2;
  localparam logic [CTRL_IW-1:0] CFG_GPIO_VAL = 4'h3;
  localparam int SERIAL_BIT = 0;
  localparam int CH_COUNT = 4;
  localparam int GPIO_COUNT = 6;
  localparam logic [5:0] GPIO_MASK_ALL = 6'h3F;
  localparam logic [5:0] GPIO_MASK_SERIAL = 6'h0F;
  // ===================================================
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SHUTDOWN_TIME_US = 100;
  localparam int SHUTDOWN_CYCLES_DEF = (SHUTDOWN_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ===================================================
  // checksum and sequencing states
  localparam logic [7:0] PEC_POLY = 8'h07;
  localparam logic [7:0] PEC_INIT = 8'h00;
  typedef enum logic [1:0] {
    OTPCL_OFF = 2'b00,
    OTPCL_LOAD = 2'b01,
    OTPCL_READY = 2'b11
  } otpcl_state_t;

  // crc-8 over address then data, msb first
  function automatic logic [7:0] otpcl_crc8(input logic [15:0] msg);
    logic [7:0] crc;
    crc = PEC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (crc[7] ^ msg[i]) begin
        crc = {crc[6:0], 1'b0} ^ PEC_POLY;
      end else begin
        crc = {crc[6:0], 1'b0};
      end
    end
    return crc;
  endfunction
endpackage

// *** hw/otpcl_loader.sv ***
// configuration loader: otp store, control and feedback registers, host port, enable sequencing
`timescale 1ns/1ps
`default_nettype none
module otpcl_loader #(
  parameter int SHUTDOWN_CYCLES = otpcl_pkg::SHUTDOWN_CYCLES_DEF
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // chip enable pin
  input wire logic chip_enable_in,
  // otp programming port
  input wire logic nvm_prog_valid_in,
  input wire logic [otpcl_pkg::CTRL_IW-1:0] nvm_prog_addr_in,
  input wire logic [otpcl_pkg::DW-1:0] nvm_prog_data_in,
  // host transfer request
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_addr_in,
  input wire logic [otpcl_pkg::DW-1:0] cmd_wdata_in,
  input wire logic [7:0] cmd_pec_in,
  // host transfer answer
  output logic rsp_valid_out,
  output logic rsp_ack_out,
  output logic [otpcl_pkg::DW-1:0] rsp_rdata_out,
  output logic [7:0] rsp_pec_out,
  // feedback from regulation logic
  input wire logic [otpcl_pkg::FB_WORDS*otpcl_pkg::DW-1:0] feedback_in,
  // chip status and controls
  output logic chip_ready_out,
  output logic shutdown_out,
  output logic [otpcl_pkg::CH_COUNT-1:0] channel_enable_out,
  output logic serial_pins_active_out,
  output logic [otpcl_pkg::GPIO_COUNT-1:0] gpio_usable_out,
  output logic [otpcl_pkg::GPIO_COUNT-1:0] gpio_out_out,
  output logic [otpcl_pkg::GPIO_COUNT-1:0] gpio_oe_out
);
  import otpcl_pkg::*;

  // ===================================================
  // storage
  logic [DW-1:0] nvm_q [CTRL_WORDS];
  logic [DW-1:0] ctrl_q [CTRL_WORDS];
  logic [DW-1:0] fb_q [FB_WORDS];
  otpcl_state_t state_q;
  logic [CTRL_IW-1:0] load_idx_q;
  logic en_q;
  logic [31:0] low_cnt_q;
  logic enable_rise;
  logic low_done;
  logic ctrl_hit;
  logic fb_hit;
  logic restart_hit;
  logic pec_ok;
  logic req_ok;
  logic restart_fire;
  logic host_ctrl_wr;
  logic [DW-1:0] rdata;

  // ===================================================
  // enable pin tracking
  assign enable_rise = chip_enable_in & ~en_q;
  assign low_done = ~chip_enable_in && (low_cnt_q == 32'(SHUTDOWN_CYCLES - 1));

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      en_q <= 1'b0;
    end else begin
      en_q <= chip_enable_in;
    end
  end

  // count consecutive low cycles so a short dip does not shut the chip down
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      low_cnt_q <= 32'h0000_0000;
    end else if (chip_enable_in || state_q == OTPCL_OFF) begin
      low_cnt_q <= 32'h0000_0000;
    end else if (!low_done) begin
      low_cnt_q <= low_cnt_q + 32'h0000_0001;
    end
  end

  // ===================================================
  // sequencing state machine
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= OTPCL_OFF;
    end else if (enable_rise || restart_fire) begin
      state_q <= OTPCL_LOAD;
    end else if (low_done) begin
      state_q <= OTPCL_OFF;
    end else begin
      case (state_q)
        OTPCL_LOAD: begin
          if (load_idx_q == LOAD_LAST) begin
            state_q <= OTPCL_READY;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // walk every otp word once per load
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      load_idx_q <= '0;
    end else if (state_q == OTPCL_LOAD && !enable_rise) begin
      load_idx_q <= load_idx_q + 4'h1;
    end else begin
      load_idx_q <= '0;
    end
  end

  // ===================================================
  // otp store: programming can only set bits, never clear them
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < CTRL_WORDS; i++) begin
        nvm_q[i] <= RESET_WORD; // blank part
      end
    end else if (nvm_prog_valid_in) begin
      nvm_q[nvm_prog_addr_in] <= nvm_q[nvm_prog_addr_in] | nvm_prog_data_in;
    end
  end

  // ===================================================
  // host request decode
  assign ctrl_hit = cmd_addr_in < CTRL_LIMIT;
  assign fb_hit = cmd_addr_in >= FB_BASE && cmd_addr_in < FB_LIMIT;
  assign restart_hit = cmd_addr_in == RESTART_ADDR;
  assign pec_ok = otpcl_crc8({cmd_addr_in, cmd_wdata_in}) == cmd_pec_in;
  // feedback space is not writable, so a write there is refused outright
  assign req_ok = cmd_valid_in && state_q == OTPCL_READY && pec_ok &&
                  (cmd_write_in ? (ctrl_hit || restart_hit) : (ctrl_hit || fb_hit));
  assign restart_fire = req_ok && cmd_write_in && restart_hit;
  assign host_ctrl_wr = req_ok && cmd_write_in && ctrl_hit;

  // control words: otp copy while loading, host writes when ready
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < CTRL_WORDS; i++) begin
        ctrl_q[i] <= RESET_WORD;
      end
    end else if (state_q == OTPCL_LOAD) begin
      ctrl_q[load_idx_q] <= nvm_q[load_idx_q];
    end else if (host_ctrl_wr) begin
      ctrl_q[cmd_addr_in[CTRL_IW-1:0]] <= cmd_wdata_in;
    end
  end

  // feedback words follow the regulation logic; host has no write path here
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < FB_WORDS; i++) begin
        fb_q[i] <= RESET_WORD;
      end
    end else begin
      for (int i = 0; i < FB_WORDS; i++) begin
        fb_q[i] <= feedback_in[i*DW +: DW];
      end
    end
  end

  // read mux
  always_comb begin
    rdata = RESET_WORD;
    if (ctrl_hit) begin
      rdata = ctrl_q[cmd_addr_in[CTRL_IW-1:0]];
    end else if (fb_hit) begin
      rdata = fb_q[cmd_addr_in[FB_IW-1:0]];
    end
  end

  // every request is answered one cycle later, nack when refused
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rsp_valid_out <= 1'b0;
      rsp_ack_out <= 1'b0;
      rsp_rdata_out <= RESET_WORD;
      rsp_pec_out <= PEC_INIT;
    end else begin
      rsp_valid_out <= cmd_valid_in;
      rsp_ack_out <= req_ok;
      rsp_rdata_out <= (req_ok && !cmd_write_in) ? rdata : RESET_WORD;
      rsp_pec_out <= otpcl_crc8({cmd_addr_in, (req_ok && !cmd_write_in) ? rdata : RESET_WORD});
    end
  end

  // ===================================================
  // chip outputs
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      chip_ready_out <= 1'b0;
      shutdown_out <= 1'b1;
      channel_enable_out <= '0;
      serial_pins_active_out <= 1'b0;
      gpio_usable_out <= GPIO_MASK_ALL;
      gpio_out_out <= '0;
      gpio_oe_out <= '0;
    end else begin
      chip_ready_out <= state_q == OTPCL_READY;
      shutdown_out <= state_q == OTPCL_OFF;
      channel_enable_out <= (state_q == OTPCL_READY) ? ctrl_q[CFG_ALWAYS_ON][CH_COUNT-1:0] : '0;
      serial_pins_active_out <= ctrl_q[CFG_GPIO_MODE][SERIAL_BIT];
      // serial pins are withheld from general use so their drivers stay off
      gpio_usable_out <= ctrl_q[CFG_GPIO_MODE][SERIAL_BIT] ? GPIO_MASK_SERIAL : GPIO_MASK_ALL;
      gpio_out_out <= ctrl_q[CFG_GPIO_VAL][GPIO_COUNT-1:0];
      gpio_oe_out <= ctrl_q[CFG_GPIO_DIR][GPIO_COUNT-1:0] &
                     (ctrl_q[CFG_GPIO_MODE][SERIAL_BIT] ? GPIO_MASK_SERIAL : GPIO_MASK_ALL);
    end
  end

  // ===================================================
  // assertions and helper state
  logic chk_load_q;
  logic [CTRL_IW-1:0] chk_idx_q;
  logic [DW-1:0] chk_word_q;
  logic chk_prog_q;
  logic [CTRL_IW-1:0] chk_paddr_q;
  logic [DW-1:0] chk_pword_q;

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      chk_load_q <= 1'b0;
      chk_idx_q <= '0;
      chk_word_q <= RESET_WORD;
      chk_prog_q <= 1'b0;
      chk_paddr_q <= '0;
      chk_pword_q <= RESET_WORD;
    end else begin
      chk_load_q <= state_q == OTPCL_LOAD;
      chk_idx_q <= load_idx_q;
      chk_word_q <= nvm_q[load_idx_q];
      chk_prog_q <= nvm_prog_valid_in;
      chk_paddr_q <= nvm_prog_addr_in;
      chk_pword_q <= nvm_q[nvm_prog_addr_in] | nvm_prog_data_in;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  a_enable_starts_load: assert property (state_q == OTPCL_OFF && enable_rise |=> state_q == OTPCL_LOAD)
    else $error("enable rise did not start a load");
  a_shutdown_after_low: assert property (state_q != OTPCL_OFF && low_done && !restart_fire |=> state_q == OTPCL_OFF)
    else $error("long enable low did not shut down");
  a_load_copies_word: assert property (chk_load_q |-> ctrl_q[chk_idx_q] == chk_word_q)
    else $error("load did not copy otp word");
  a_load_then_ready: assert property (state_q == OTPCL_LOAD && load_idx_q == LOAD_LAST && !enable_rise && !low_done
                                      |=> state_q == OTPCL_READY ##1 chip_ready_out)
    else $error("ready not raised after last word");
  a_otp_bits_stick: assert property (chk_prog_q |-> nvm_q[chk_paddr_q] == chk_pword_q)
    else $error("otp programming cleared or missed a bit");
  a_ack_needs_ready: assert property (cmd_valid_in && state_q != OTPCL_READY |=> rsp_valid_out && !rsp_ack_out)
    else $error("request acknowledged before ready");
  a_bad_pec_nack: assert property (cmd_valid_in && !pec_ok |=> rsp_valid_out && !rsp_ack_out)
    else $error("bad checksum acknowledged");
  a_fb_write_kept: assert property (cmd_valid_in && cmd_write_in && fb_hit |=> !rsp_ack_out)
    else $error("feedback write accepted");
  a_restart_reload: assert property (restart_fire |=> state_q == OTPCL_LOAD ##1 !chip_ready_out)
    else $error("restart did not reload");
  a_serial_pins_free: assert property (serial_pins_active_out |-> (gpio_oe_out & ~GPIO_MASK_SERIAL) == '0)
    else $error("serial pins driven as gpio");
  a_channels_need_ready: assert property (channel_enable_out != '0 |-> $past(state_q) == OTPCL_READY)
    else $error("channel enabled without ready");

  c_load_done: cover property (state_q == OTPCL_LOAD ##1 state_q == OTPCL_READY);
  c_host_write: cover property (host_ctrl_wr ##1 rsp_ack_out);
  c_restart: cover property (restart_fire);
  c_shutdown: cover property (state_q == OTPCL_READY ##1 state_q == OTPCL_OFF);
endmodule
`default_nettype wire

// *** tb/otpcl_host.sv ***
// host model: frames one checked transfer per start pulse
`timescale 1ns/1ps
`default_nettype none
module otpcl_host (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // request from bench
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic bad_pec_in,
  // transfer to device
  output logic cmd_valid_out,
  output logic cmd_write_out,
  output logic [7:0] cmd_addr_out,
  output logic [7:0] cmd_wdata_out,
  output logic [7:0] cmd_pec_out
);
  // own checksum copy, so expectations never lean on the design's
  function automatic logic [7:0] crc(input logic [15:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
  // one-cycle request; idle fields toggle so stale values never match
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cmd_valid_out <= 1'b0;
      cmd_write_out <= 1'b0;
      cmd_addr_out <= 8'h00;
      cmd_wdata_out <= 8'h00;
      cmd_pec_out <= 8'h00;
    end else if (start_in) begin
      cmd_valid_out <= 1'b1;
      cmd_write_out <= write_in;
      cmd_addr_out <= addr_in;
      cmd_wdata_out <= data_in;
      cmd_pec_out <= crc({addr_in, data_in}) ^ {7'h00, bad_pec_in};
    end else begin
      cmd_valid_out <= 1'b0;
      cmd_write_out <= ~cmd_write_out;
      cmd_addr_out <= ~cmd_addr_out;
      cmd_wdata_out <= ~cmd_wdata_out;
      cmd_pec_out <= ~cmd_pec_out;
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import otpcl_pkg::*;
  logic ref_clk_in, reset_in, en, pv, st, wr, bp, cv, cw, rv, rk, rdy, sd, spa;
  logic [3:0] pa, ch;
  logic [7:0] pd, ad, da, ca, cd, cp, rd, rp;
  logic [5:0] us, go, oe;
  logic [63:0] fb;
  int num_errors, checks_done, n;
  int cyc = 0;
  // short shutdown count keeps the run brief
  otpcl_loader #(.SHUTDOWN_CYCLES(20)) otpcl_loader_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .chip_enable_in(en), .nvm_prog_valid_in(pv), .nvm_prog_addr_in(pa), .nvm_prog_data_in(pd),
    .cmd_valid_in(cv), .cmd_write_in(cw), .cmd_addr_in(ca), .cmd_wdata_in(cd), .cmd_pec_in(cp),
    .rsp_valid_out(rv), .rsp_ack_out(rk), .rsp_rdata_out(rd), .rsp_pec_out(rp), .feedback_in(fb),
    .chip_ready_out(rdy), .shutdown_out(sd), .channel_enable_out(ch), .serial_pins_active_out(spa),
    .gpio_usable_out(us), .gpio_out_out(go), .gpio_oe_out(oe));
  otpcl_host otpcl_host_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .start_in(st), .write_in(wr),
    .addr_in(ad), .data_in(da), .bad_pec_in(bp), .cmd_valid_out(cv), .cmd_write_out(cw),
    .cmd_addr_out(ca), .cmd_wdata_out(cd), .cmd_pec_out(cp));
  // clock
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  // hang guard, well above the roughly 140 cycles needed
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic prog(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    pv <= 1'b1;
    pa <= a;
    pd <= d;
    @(posedge ref_clk_in);
    pv <= 1'b0;
  endtask
  // one transfer; the answer is a single-cycle pulse, looked at in its cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic bad,
    input logic ea, input logic [7:0] er);
    @(posedge ref_clk_in);
    st <= 1'b1;
    wr <= w;
    ad <= a;
    da <= d;
    bp <= bad;
    @(posedge ref_clk_in);
    st <= 1'b0;
    tick(1);
    check(rv, 1'b1);
    check(rk, ea);
    check(rd, er);
    if (ea) check(rp, otpcl_host_i.crc({a, er}));
  endtask
  task automatic wait_ready();
    n = 0;
    while (rdy !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
  endtask
  task automatic t_load();
    check(sd, 1'b1);
    check(us, 6'h3F);
    xfer(1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00);
    prog(4'h0, 8'h05);
    prog(4'h0, 8'h02);
    prog(4'h2, 8'h3F);
    prog(4'h3, 8'h2A);
    @(posedge ref_clk_in);
    en <= 1'b1;
    wait_ready();
    check(8'(n), 8'h12);
    check(ch, 4'h7);
    check(oe, 6'h3F);
    check(go, 6'h2A);
    $display("test load done");
  endtask
  task automatic t_host();
    xfer(1'b1, 8'h01, 8'h01, 1'b0, 1'b1, 8'h00);
    tick(2);
    check(spa, 1'b1);
    check(us, 6'h0F);
    check(oe, 6'h0F);
    xfer(1'b0, 8'h01, 8'h00, 1'b0, 1'b1, 8'h01);
    xfer(1'b0, 8'h43, 8'h00, 1'b0, 1'b1, 8'h44);
    xfer(1'b1, 8'h43, 8'h99, 1'b0, 1'b0, 8'h00);
    xfer(1'b0, 8'h43, 8'h00, 1'b0, 1'b1, 8'h44);
    xfer(1'b1, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
    xfer(1'b0, 8'h00, 8'h00, 1'b0, 1'b1, 8'h07);
    xfer(1'b0, 8'h20, 8'h00, 1'b0, 1'b0, 8'h00);
    $display("test host done");
  endtask
  task automatic t_restart();
    xfer(1'b1, 8'h00, 8'h00, 1'b0, 1'b1, 8'h00);
    tick(2);
    check(ch, 4'h0);
    xfer(1'b1, RESTART_ADDR, 8'h5A, 1'b0, 1'b1, 8'h00);
    tick(2);
    check(rdy, 1'b0);
    wait_ready();
    check(ch, 4'h7);
    check(us, 6'h3F);
    check(spa, 1'b0);
    $display("test restart done");
  endtask
  task automatic t_enable();
    @(posedge ref_clk_in);
    en <= 1'b0;
    tick(10);
    // short dip must not reach shutdown
    check(sd, 1'b0);
    @(posedge ref_clk_in);
    en <= 1'b1;
    // ready drops two edges after the rise is driven, then sixteen more to reload
    tick(2);
    check(rdy, 1'b0);
    wait_ready();
    check(8'(n), 8'h10);
    check(ch, 4'h7);
    @(posedge ref_clk_in);
    en <= 1'b0;
    tick(20);
    check(sd, 1'b0);
    tick(1);
    check(sd, 1'b1);
    check(rdy, 1'b0);
    check(ch, 4'h0);
    $display("test enable done");
  endtask
  // main sequence
  initial begin
    {reset_in, en, pv, st, wr, bp} = 6'h20;
    {pa, pd, ad, da} = 28'h0;
    fb = 64'h8877665544332211;
    num_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    tick(1);
    t_load();
    t_host();
    t_restart();
    t_enable();
    wrap_up();
  end
endmodule
`default_nettype wire
